// ==== hdl/i2cs_defines.svh ====
`ifndef I2CS_DEFINES_SVH
`define I2CS_DEFINES_SVH

// register offsets on the plain register port
`define I2CS_OFS_STATUS 2'h0
`define I2CS_OFS_OUTDATA 2'h1
`define I2CS_OFS_INDATA 2'h2

// status_control_reg bit positions
`define I2CS_BIT_STOP_WR 0
`define I2CS_BIT_STOP_RD 1
`define I2CS_BIT_TX_IE 2
`define I2CS_BIT_TX_EMPTY 3
`define I2CS_BIT_FAST 4
`define I2CS_BIT_BUS_ERR 5
`define I2CS_BIT_RX_IE 6
`define I2CS_BIT_RX_FULL 7

// reset values
`define I2CS_RST_BYTE 8'h00
`define I2CS_RST_TX_EMPTY 1'b1
`define I2CS_RST_CLEAR 1'b0

// clock and bus rates in Hz
`define I2CS_CLK_HZ 32'h0262_5A00
`define I2CS_STD_HZ 32'h0001_86A0
`define I2CS_FAST_HZ 32'h0006_1A80

`endif

// ==== hdl/i2cs_pkg.sv ====
package i2cs_pkg;
    typedef logic [7:0] i2cs_byte_t;
    typedef logic [1:0] i2cs_addr_t;
endpackage

// ==== hdl/i2cs_rate_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "i2cs_defines.svh"
module i2cs_rate_gen #(
    parameter int unsigned CLK_HZ = `I2CS_CLK_HZ,
    parameter int unsigned STD_HZ = `I2CS_STD_HZ,
    parameter int unsigned FAST_HZ = `I2CS_FAST_HZ
) (
    input wire logic mclk,
    input wire logic nrst,
    i2cs_rate_if.gen rate
);
    // cycles of mclk in one serial bit period
    function automatic logic [15:0] period_cycles(input int unsigned hz);
        int unsigned n;
        n = CLK_HZ / hz;
        period_cycles = n[15:0];
    endfunction

    localparam logic [15:0] STD_CYC = period_cycles(STD_HZ);
    localparam logic [15:0] FAST_CYC = period_cycles(FAST_HZ);

    // refuse rates the counter cannot serve
    if (CLK_HZ / FAST_HZ < 2 || CLK_HZ / STD_HZ > 65535 || STD_HZ > FAST_HZ)
    begin : g_chk
        $error("i2cs_rate_gen: unusable clock or bus rate");
    end

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;
    logic [15:0] limit;

    // divider reloads at the period chosen by the speed select
    always_comb
    begin
        limit = rate.fast_sel ? FAST_CYC : STD_CYC;
        nxt_tick = 1'b0;
        if (cnt_ff >= limit - 16'h0001)
        begin
            nxt_cnt = 16'h0000;
            nxt_tick = 1'b1;
        end
        else
        begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign rate.bit_tick = tick_ff;
endmodule // i2cs_rate_gen
`default_nettype wire

// ==== hdl/i2cs_rate_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface i2cs_rate_if;
    logic fast_sel;
    logic bit_tick;
    modport ctrl (output fast_sel, input bit_tick);
    modport gen (input fast_sel, output bit_tick);
endinterface
`default_nettype wire

// ==== hdl/i2cs_status_ctrl.sv ====
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "i2cs_defines.svh"
module i2cs_status_ctrl (
    input wire logic mclk,
    input wire logic nrst,
    input wire i2cs_pkg::i2cs_addr_t reg_addr,
    input wire i2cs_pkg::i2cs_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic copy_done,
    input wire logic rx_load,
    input wire i2cs_pkg::i2cs_byte_t rx_byte,
    input wire logic nack,
    output logic xfer_start,
    output logic [7:0] tx_byte,
    output logic stop_after_write,
    output logic stop_after_read,
    output logic fast_mode,
    output logic bit_tick,
    output logic irq
);
    i2cs_rate_if rate_bus ();

    // state flops
    logic stop_wr_ff;
    logic stop_rd_ff;
    logic tx_empty_irq_enable_ff;
    logic tx_buffer_empty_ff;
    logic fast_ff;
    logic bus_err_ff;
    logic rx_ready_irq_enable_ff;
    logic rx_buffer_full_ff;
    i2cs_pkg::i2cs_byte_t output_data_reg_ff;
    i2cs_pkg::i2cs_byte_t input_data_reg_ff;
    i2cs_pkg::i2cs_byte_t rdata_ff;
    logic start_ff;
    logic irq_ff;

    logic nxt_stop_wr;
    logic nxt_stop_rd;
    logic nxt_tx_empty_irq_enable;
    logic nxt_tx_buffer_empty;
    logic nxt_fast;
    logic nxt_bus_err;
    logic nxt_rx_ready_irq_enable;
    logic nxt_rx_buffer_full;
    i2cs_pkg::i2cs_byte_t nxt_output_data_reg;
    i2cs_pkg::i2cs_byte_t nxt_input_data_reg;
    i2cs_pkg::i2cs_byte_t nxt_rdata;
    logic nxt_start;
    logic nxt_irq;

    logic wr_status;
    logic wr_outdata;
    logic rd_indata;
    i2cs_pkg::i2cs_byte_t status_view;

    // a strobe that lands on one register index
    function automatic logic addr_hit(
        input logic strobe,
        input i2cs_pkg::i2cs_addr_t addr,
        input i2cs_pkg::i2cs_addr_t ofs
    );
        addr_hit = strobe && (addr == ofs);
    endfunction

    // address decode of the register port
    assign wr_status = addr_hit(reg_wr, reg_addr, `I2CS_OFS_STATUS);
    assign wr_outdata = addr_hit(reg_wr, reg_addr, `I2CS_OFS_OUTDATA);
    assign rd_indata = addr_hit(reg_rd, reg_addr, `I2CS_OFS_INDATA);

    // status register as software sees it
    always_comb
    begin
        status_view = `I2CS_RST_BYTE;
        status_view[`I2CS_BIT_STOP_WR] = stop_wr_ff;
        status_view[`I2CS_BIT_STOP_RD] = stop_rd_ff;
        status_view[`I2CS_BIT_TX_IE] = tx_empty_irq_enable_ff;
        status_view[`I2CS_BIT_TX_EMPTY] = tx_buffer_empty_ff;
        status_view[`I2CS_BIT_FAST] = fast_ff;
        status_view[`I2CS_BIT_BUS_ERR] = bus_err_ff;
        status_view[`I2CS_BIT_RX_IE] = rx_ready_irq_enable_ff;
        status_view[`I2CS_BIT_RX_FULL] = rx_buffer_full_ff;
    end

    // next values of control bits, flags, data and read port
    always_comb
    begin
        nxt_stop_wr = stop_wr_ff;
        nxt_stop_rd = stop_rd_ff;
        nxt_tx_empty_irq_enable = tx_empty_irq_enable_ff;
        nxt_fast = fast_ff;
        nxt_rx_ready_irq_enable = rx_ready_irq_enable_ff;
        nxt_output_data_reg = output_data_reg_ff;
        nxt_input_data_reg = input_data_reg_ff;
        nxt_tx_buffer_empty = tx_buffer_empty_ff;
        nxt_bus_err = bus_err_ff;
        nxt_rx_buffer_full = rx_buffer_full_ff;
        nxt_start = 1'b0;
        nxt_rdata = `I2CS_RST_BYTE;
        // flag bits 3 and 7 are read-only here, bit 5 only ever clears
        if (wr_status)
        begin
            nxt_stop_wr = reg_wdata[`I2CS_BIT_STOP_WR];
            nxt_stop_rd = reg_wdata[`I2CS_BIT_STOP_RD];
            nxt_tx_empty_irq_enable = reg_wdata[`I2CS_BIT_TX_IE];
            nxt_fast = reg_wdata[`I2CS_BIT_FAST];
            nxt_rx_ready_irq_enable = reg_wdata[`I2CS_BIT_RX_IE];
            if (reg_wdata[`I2CS_BIT_BUS_ERR])
            begin
                nxt_bus_err = 1'b0;
            end
        end
        if (wr_outdata)
        begin
            nxt_output_data_reg = reg_wdata;
            nxt_start = 1'b1;
            nxt_tx_buffer_empty = 1'b0;
        end
        // hardware sets win over clears in the same cycle
        if (copy_done)
        begin
            nxt_tx_buffer_empty = 1'b1;
        end
        if (nack)
        begin
            nxt_bus_err = 1'b1;
        end
        // a load beside the read keeps the flag set, the read sees the old byte
        if (rd_indata)
        begin
            nxt_rx_buffer_full = 1'b0;
        end
        if (rx_load)
        begin
            nxt_input_data_reg = rx_byte;
            nxt_rx_buffer_full = 1'b1;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                `I2CS_OFS_STATUS: nxt_rdata = status_view;
                `I2CS_OFS_OUTDATA: nxt_rdata = output_data_reg_ff;
                `I2CS_OFS_INDATA: nxt_rdata = input_data_reg_ff;
                default: nxt_rdata = `I2CS_RST_BYTE; // unmapped reads zero
            endcase
        end
        // interrupt from the new flag and enable values
        nxt_irq = (nxt_tx_buffer_empty && nxt_tx_empty_irq_enable)
            || (nxt_rx_buffer_full && nxt_rx_ready_irq_enable);
    end

    // register all state
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stop_wr_ff <= `I2CS_RST_CLEAR;
            stop_rd_ff <= `I2CS_RST_CLEAR;
            tx_empty_irq_enable_ff <= `I2CS_RST_CLEAR;
            tx_buffer_empty_ff <= `I2CS_RST_TX_EMPTY;
            fast_ff <= `I2CS_RST_CLEAR;
            bus_err_ff <= `I2CS_RST_CLEAR;
            rx_ready_irq_enable_ff <= `I2CS_RST_CLEAR;
            rx_buffer_full_ff <= `I2CS_RST_CLEAR;
            output_data_reg_ff <= `I2CS_RST_BYTE;
            input_data_reg_ff <= `I2CS_RST_BYTE;
            rdata_ff <= `I2CS_RST_BYTE;
            start_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            stop_wr_ff <= nxt_stop_wr;
            stop_rd_ff <= nxt_stop_rd;
            tx_empty_irq_enable_ff <= nxt_tx_empty_irq_enable;
            tx_buffer_empty_ff <= nxt_tx_buffer_empty;
            fast_ff <= nxt_fast;
            bus_err_ff <= nxt_bus_err;
            rx_ready_irq_enable_ff <= nxt_rx_ready_irq_enable;
            rx_buffer_full_ff <= nxt_rx_buffer_full;
            output_data_reg_ff <= nxt_output_data_reg;
            input_data_reg_ff <= nxt_input_data_reg;
            rdata_ff <= nxt_rdata;
            start_ff <= nxt_start;
            irq_ff <= nxt_irq;
        end
    end

    // serial bit-rate generator follows the speed select
    assign rate_bus.fast_sel = fast_ff;

    i2cs_rate_gen u_rate (
        .mclk (mclk),
        .nrst (nrst),
        .rate (rate_bus.gen)
    );

    // outputs
    assign reg_rdata = rdata_ff;
    assign xfer_start = start_ff;
    assign tx_byte = output_data_reg_ff;
    assign stop_after_write = stop_wr_ff;
    assign stop_after_read = stop_rd_ff;
    assign fast_mode = fast_ff;
    assign bit_tick = rate_bus.bit_tick;
    assign irq = irq_ff;
endmodule // i2cs_status_ctrl
`default_nettype wire

// ==== tb/i2c_master_status_flags_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_master_status_flags_tb_top;
    typedef struct packed {logic [1:0] a; logic [7:0] d; logic [7:0] e; logic q;
        logic [1:0] s;} i2cs_row_t;
    logic mclk, nrst, reg_wr, reg_rd, copy_done, rx_load, nack, xfer_start, fast_mode, irq, slow;
    logic stop_after_write, stop_after_read, bit_tick;
    logic [1:0] reg_addr, mode;
    logic [7:0] reg_wdata, rx_byte, reg_rdata, tx_byte;
    int error_cnt = 0;
    int total_checks = 0;
    // address, write data, read-back, irq, stop bits
    i2cs_row_t rows [5] = '{'{2'h0, 8'h57, 8'h5F, 1'b1, 2'h3}, '{2'h0, 8'h80, 8'h08, 1'b0, 2'h0},
        '{2'h3, 8'hFF, 8'h00, 1'b0, 2'h0}, '{2'h2, 8'h55, 8'h00, 1'b0, 2'h0},
        '{2'h1, 8'hA5, 8'hA5, 1'b0, 2'h0}};
    i2cs_status_ctrl dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .copy_done(copy_done),
        .rx_load(rx_load), .rx_byte(rx_byte), .nack(nack), .xfer_start(xfer_start),
        .tx_byte(tx_byte), .stop_after_write(stop_after_write),
        .stop_after_read(stop_after_read), .fast_mode(fast_mode),
        .bit_tick(bit_tick), .irq(irq));
    i2cs_shift_model u_eng (.mclk(mclk), .nrst(nrst), .xfer_start(xfer_start),
        .tx_byte(tx_byte), .mode(mode), .slow(slow), .copy_done(copy_done),
        .rx_load(rx_load), .rx_byte(rx_byte), .nack(nack));
    // 40 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic give_verdict(input int fail);
        error_cnt += fail;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // one bus cycle, driven just after an edge
    task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rdc(input string n, input logic [1:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        chk(n, reg_rdata, e);
    endtask
    // idle until an engine strobe in mask m shows, bounded
    task automatic wt(input logic [2:0] m);
        int n;
        n = 0;
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        while ((m & {nack, rx_load, copy_done}) == 3'h0)
        begin
            n++;
            if (n == 200)
                give_verdict(1);
            bus(1'b0, 1'b0, 2'h0, 8'h00);
        end
        bus(1'b0, 1'b0, 2'h0, 8'h00);
    endtask
    // cycles from one bit tick to the next, bounded
    task automatic tick_gap(input string n, input logic [15:0] e);
        int c;
        c = 0;
        while (bit_tick !== 1'b1)
        begin
            c++;
            if (c == 1000)
                give_verdict(1);
            bus(1'b0, 1'b0, 2'h0, 8'h00);
        end
        c = 0;
        do
        begin
            c++;
            if (c == 1000)
                give_verdict(1);
            bus(1'b0, 1'b0, 2'h0, 8'h00);
        end
        while (bit_tick !== 1'b1);
        chk(n, 16'(c), e);
    endtask
    // hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        give_verdict(1);
    end
    // reset, table rows, then transfer cases
    initial
    begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, mode, slow} = '0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        rdc("status", 2'h0, 8'h08);
        chk("irq", 8'(irq), 8'h00);
        chk("speed", 8'(fast_mode), 8'h00);
        $display("reset done");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rdc("row data", rows[i].a, rows[i].e);
            chk("row irq", 8'(irq), 8'(rows[i].q));
            chk("row stop", 8'({stop_after_read, stop_after_write}), 8'(rows[i].s));
        end
        // let the transfer started by the last row finish before the next case
        wt(3'h1);
        $display("rows done");
        slow <= 1'b1;
        wr(2'h0, 8'h04);
        wr(2'h1, 8'h3C);
        chk("start", 8'(xfer_start), 8'h01);
        chk("tx byte", tx_byte, 8'h3C);
        rdc("busy", 2'h0, 8'h04);
        chk("busy irq", 8'(irq), 8'h00);
        wt(3'h1);
        chk("tx irq", 8'(irq), 8'h01);
        rdc("empty", 2'h0, 8'h0C);
        $display("transmit done");
        mode <= 2'h1;
        slow <= 1'b0;
        wr(2'h0, 8'h40);
        wr(2'h1, 8'hC3);
        wt(3'h2);
        chk("rx irq", 8'(irq), 8'h01);
        rdc("full", 2'h0, 8'hC8);
        rdc("rx byte", 2'h2, 8'h3C);
        rdc("drained", 2'h0, 8'h48);
        $display("receive done");
        mode <= 2'h2;
        wr(2'h1, 8'h11);
        wt(3'h4);
        rdc("error", 2'h0, 8'h68);
        wr(2'h0, 8'h40);
        rdc("error kept", 2'h0, 8'h68);
        wr(2'h0, 8'h60);
        rdc("error gone", 2'h0, 8'h48);
        $display("error done");
        tick_gap("slow period", 16'h0190);
        wr(2'h0, 8'h17);
        chk("fast", 8'(fast_mode), 8'h01);
        chk("irq on", 8'(irq), 8'h01);
        tick_gap("fast period", 16'h0064);
        $display("speed done");
        // reset in mid-run returns every flag and control bit to its reset value
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        rdc("status again", 2'h0, 8'h08);
        chk("irq again", 8'(irq), 8'h00);
        chk("speed again", 8'(fast_mode), 8'h00);
        chk("stop again", 8'({stop_after_read, stop_after_write}), 8'h00);
        chk("tx byte again", tx_byte, 8'h00);
        $display("reset again done");
        give_verdict(0);
    end
endmodule // i2c_master_status_flags_tb_top
`default_nettype wire

// ==== tb/i2cs_shift_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2cs_shift_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic xfer_start,
    input wire logic [7:0] tx_byte,
    input wire logic [1:0] mode,
    input wire logic slow,
    output logic copy_done,
    output logic rx_load,
    output logic [7:0] rx_byte,
    output logic nack
);
    int cnt;
    logic [7:0] held;
    // take the byte a while after a start, then answer as mode asks
    always @(posedge mclk or negedge nrst)
    begin
        cnt <= !nrst ? 0 : xfer_start ? (slow ? 40 : 3) : cnt - (cnt > 0);
        held <= xfer_start ? tx_byte : held;
        copy_done <= nrst && cnt == 2;
        rx_load <= nrst && cnt == 1 && mode[0];
        nack <= nrst && cnt == 1 && mode[1];
        rx_byte <= !nrst ? 8'h00 : cnt == 1 ? ~held : ~rx_byte; // idle data keeps moving
    end
endmodule // i2cs_shift_model
`default_nettype wire

// ==== tb/i2cs_status_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2cs_status_sva (
    input wire logic mclk,
    input wire logic nrst,
    input wire i2cs_pkg::i2cs_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic copy_done,
    input wire logic rx_load,
    input wire logic nack,
    input wire logic xfer_start
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // status read and output data write
    sequence s_sta; reg_rd && reg_addr == 2'h0; endsequence
    sequence s_out; reg_wr && reg_addr == 2'h1; endsequence
    // start strobe, idle read data, and flags seen through status reads
    chk_start_pulse: assert property (s_out |=> xfer_start)
        else $error("no start");
    chk_start_cause: assert property (xfer_start |-> $past(reg_wr && reg_addr == 2'h1))
        else $error("stray start");
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("stray data");
    chk_txe_set: assert property (copy_done ##1 s_sta |=> reg_rdata[3])
        else $error("empty not set");
    chk_txe_busy: assert property (
        reg_wr && reg_addr == 2'h1 && !copy_done ##1 reg_rd && reg_addr == 2'h0 && !copy_done
        |=> !reg_rdata[3]) else $error("empty not cleared");
    chk_rxf_set: assert property (rx_load ##1 s_sta |=> reg_rdata[7])
        else $error("full not set");
    chk_err_set: assert property (nack ##1 s_sta |=> reg_rdata[5])
        else $error("error not set");
    chk_rxf_clr: assert property (
        reg_rd && reg_addr == 2'h2 && !rx_load ##1 reg_rd && reg_addr == 2'h0 && !rx_load
        |=> !reg_rdata[7]) else $error("full not cleared");
endmodule // i2cs_status_sva
bind i2cs_status_ctrl i2cs_status_sva u_sva (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .copy_done(copy_done),
    .rx_load(rx_load), .nack(nack), .xfer_start(xfer_start));
`default_nettype wire
